/* dcld_defs.svh */
`ifndef DCLD_DEFS_SVH
`define DCLD_DEFS_SVH
// Functional notes
// - Write command 000 stores code in selected staging
// - Staging write leaves outputs unless latch transparent
// - Select bits 18:16 pick A-D; 1XX picks all
// - Command 001 copies staging to selected outputs
// - Load to all leaves staging registers untouched
// - Load command 001 ignores all sixteen data bits
// - Write command accepted with multibyte flag set
// - Load command accepted with multibyte flag set
// - Command 010 writes selected, loads all modified outputs
// - Command 011 writes and loads selected only
// - Unmodified channels skip output update on combined

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define DCLD_CMD_WRITE       3'h0
`define DCLD_CMD_LOAD        3'h1
`define DCLD_CMD_WRITE_EVERY 3'h2
`define DCLD_CMD_WRITE_CHOSE 3'h3

// ---------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DCLD_IDX_CTRL        4'h0
`define DCLD_IDX_STATUS      4'h1
`define DCLD_IDX_STAGE0      4'h4
`define DCLD_IDX_OUT0        4'h8
`define DCLD_CTRL_TRANSP_BIT 0
`define DCLD_CTRL_RESET      1'h0
`define DCLD_CODE_RESET      12'h000
`define DCLD_RESP_OKAY       2'h0
`define DCLD_RESP_SLVERR     2'h2
`endif

/* dcld_pkg.sv */
package dcld_pkg;
  typedef logic [11:0] dcld_code_t;
  typedef logic [3:0][11:0] dcld_codes_t;

  typedef struct packed {
    logic       reserved;
    logic       multibyte;
    logic [2:0] command;
    logic       channel_select_msb;
    logic       channel_select_mid;
    logic       channel_select_lsb;
    dcld_code_t sample_value;
    logic [3:0] ignored;
  } dcld_frame_s;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } dcld_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dcld_axi_rsp_s;
endpackage

/* dcld_decoder.sv */
`timescale 1ns/10ps
`include "dcld_defs.svh"
module dcld_decoder (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 frame_valid,
  input  wire dcld_pkg::dcld_frame_s frame,
  input  wire dcld_pkg::dcld_axi_req_s axi_req,
  output      dcld_pkg::dcld_axi_rsp_s axi_rsp,
  output      dcld_pkg::dcld_codes_t  dac_code
);
  import dcld_pkg::*;

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  logic [2:0]  chsel;
  logic        fr_ok;
  logic        is_wr;
  logic [3:0]  sel;
  logic        transp_r;
  logic        transp_nxt;
  dcld_codes_t stage_r;
  dcld_codes_t stage_nxt;
  dcld_codes_t out_r;
  dcld_codes_t out_nxt;
  logic [3:0]  dirty_r;
  logic [3:0]  dirty_nxt;
  logic [3:0]  dirty_now;
  logic [3:0]  load;
  logic [2:0]  last_cmd_r;
  logic [2:0]  last_cmd_nxt;
  logic        last_mb_r;
  logic        last_mb_nxt;

  assign chsel = {frame.channel_select_msb, frame.channel_select_mid,
                  frame.channel_select_lsb};
  // The multibyte flag does not alter decoding of any frame.
  assign fr_ok = frame_valid & ~frame.reserved;
  assign is_wr = fr_ok & (frame.command == `DCLD_CMD_WRITE
                 || frame.command == `DCLD_CMD_WRITE_EVERY
                 || frame.command == `DCLD_CMD_WRITE_CHOSE);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ch
      assign sel[gi] = chsel[2] | (chsel[1:0] == 2'(gi));
      assign stage_nxt[gi] = (is_wr & sel[gi]) ? frame.sample_value
                                               : stage_r[gi];
      assign dirty_now[gi] = dirty_r[gi] | (is_wr & sel[gi]);
      // Load ignores data bits; combined loads skip unmodified channels.
      assign load[gi] =
          (fr_ok & frame.command == `DCLD_CMD_LOAD & sel[gi])
        | (fr_ok & frame.command == `DCLD_CMD_WRITE_EVERY & dirty_now[gi])
        | (fr_ok & frame.command == `DCLD_CMD_WRITE_CHOSE & sel[gi]
           & dirty_now[gi])
        | (transp_r & is_wr & sel[gi]);
      assign out_nxt[gi]   = load[gi] ? stage_nxt[gi] : out_r[gi];
      assign dirty_nxt[gi] = load[gi] ? 1'b0 : dirty_now[gi];
    end
  endgenerate

  always_comb
  begin
    last_cmd_nxt = last_cmd_r;
    last_mb_nxt  = last_mb_r;
    if (fr_ok)
    begin
      last_cmd_nxt = frame.command;
      last_mb_nxt  = frame.multibyte;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage_r    <= {4{`DCLD_CODE_RESET}};
      out_r      <= {4{`DCLD_CODE_RESET}};
      dirty_r    <= 4'h0;
      last_cmd_r <= 3'h0;
      last_mb_r  <= 1'b0;
    end
    else
    begin
      stage_r    <= stage_nxt;
      out_r      <= out_nxt;
      dirty_r    <= dirty_nxt;
      last_cmd_r <= last_cmd_nxt;
      last_mb_r  <= last_mb_nxt;
    end
  end

  assign dac_code = out_r;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_got_r;
  logic        aw_got_nxt;
  logic        w_got_r;
  logic        w_got_nxt;
  logic [7:0]  awaddr_r;
  logic [7:0]  awaddr_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0]  wstrb_r;
  logic [3:0]  wstrb_nxt;
  logic        do_wr;
  logic [3:0]  widx;
  logic [3:0]  ridx;
  logic        rmapped;
  logic [31:0] rword;
  dcld_axi_rsp_s rsp_r;
  dcld_axi_rsp_s rsp_nxt;

  assign do_wr = aw_got_r & w_got_r & ~rsp_r.bvalid;
  assign widx  = awaddr_r[5:2];
  assign ridx  = axi_req.araddr[5:2];

  always_comb
  begin
    rword   = 32'h0000_0000;
    rmapped = (axi_req.araddr[7:6] == 2'h0);
    unique case (ridx)
      `DCLD_IDX_CTRL:   rword = {31'h0000_0000, transp_r};
      `DCLD_IDX_STATUS: rword = {24'h00_0000, dirty_r, last_cmd_r, last_mb_r};
      4'h4, 4'h5, 4'h6, 4'h7: rword = {20'h0_0000, stage_r[ridx[1:0]]};
      4'h8, 4'h9, 4'hA, 4'hB: rword = {20'h0_0000, out_r[ridx[1:0]]};
      default:          rmapped = 1'b0;
    endcase
  end

  always_comb
  begin
    rsp_nxt    = rsp_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    transp_nxt = transp_r;
    if (axi_req.awvalid && rsp_r.awready)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = axi_req.awaddr;
    end
    if (axi_req.wvalid && rsp_r.wready)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = axi_req.wdata;
      wstrb_nxt = axi_req.wstrb;
    end
    if (rsp_r.bvalid && axi_req.bready)
      rsp_nxt.bvalid = 1'b0;
    if (do_wr)
    begin
      aw_got_nxt     = 1'b0;
      w_got_nxt      = 1'b0;
      rsp_nxt.bvalid = 1'b1;
      rsp_nxt.bresp  = `DCLD_RESP_OKAY;
      if (awaddr_r[7:6] == 2'h0 && widx == `DCLD_IDX_CTRL)
      begin
        if (wstrb_r[0])
          transp_nxt = wdata_r[`DCLD_CTRL_TRANSP_BIT];
      end
      else if (!(awaddr_r[7:6] == 2'h0 && (widx == `DCLD_IDX_STATUS
                 || widx[3:2] == 2'h1 || widx[3:2] == 2'h2)))
        rsp_nxt.bresp = `DCLD_RESP_SLVERR;
    end
    rsp_nxt.awready = ~aw_got_nxt & ~rsp_nxt.bvalid;
    rsp_nxt.wready  = ~w_got_nxt & ~rsp_nxt.bvalid;
    if (rsp_r.rvalid && axi_req.rready)
      rsp_nxt.rvalid = 1'b0;
    if (axi_req.arvalid && rsp_r.arready)
    begin
      rsp_nxt.rvalid = 1'b1;
      rsp_nxt.rdata  = rmapped ? rword : 32'h0000_0000;
      rsp_nxt.rresp  = rmapped ? `DCLD_RESP_OKAY : `DCLD_RESP_SLVERR;
    end
    rsp_nxt.arready = ~rsp_nxt.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rsp_r    <= '0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      transp_r <= `DCLD_CTRL_RESET;
    end
    else
    begin
      rsp_r    <= rsp_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      transp_r <= transp_nxt;
    end
  end

  assign axi_rsp = rsp_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [2:0] f_cmd;
  assign f_cmd = frame.command;

  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_chk
      property p_write_stores;
        fr_ok && f_cmd == 3'h0 && sel[gi] |=> stage_r[gi] == $past(frame.sample_value);
      endproperty
      a_write_stores: assert property (p_write_stores)
        else $error("staging write not stored");
      property p_write_keeps_out;
        fr_ok && f_cmd == 3'h0 && !transp_r |=> $stable(out_r[gi]);
      endproperty
      a_write_keeps_out: assert property (p_write_keeps_out)
        else $error("staging write changed output");
      property p_load_copies;
        fr_ok && f_cmd == 3'h1 && sel[gi] |=> out_r[gi] == $past(stage_r[gi]);
      endproperty
      a_load_copies: assert property (p_load_copies)
        else $error("load did not copy staging");
      property p_every_loads;
        fr_ok && f_cmd == 3'h2 && sel[gi] |=> out_r[gi] == $past(frame.sample_value);
      endproperty
      a_every_loads: assert property (p_every_loads)
        else $error("write then load every failed");
      property p_chosen_only;
        fr_ok && f_cmd == 3'h3 && !sel[gi] && !transp_r |=> $stable(out_r[gi]);
      endproperty
      a_chosen_only: assert property (p_chosen_only)
        else $error("unselected output changed");
      property p_skip_clean;
        fr_ok && f_cmd == 3'h2 && !sel[gi] && !dirty_r[gi] |=> $stable(out_r[gi]);
      endproperty
      a_skip_clean: assert property (p_skip_clean)
        else $error("unmodified channel updated");
    end
  endgenerate

  property p_all_select;
    fr_ok && f_cmd == 3'h0 && chsel[2]
      |=> stage_r[0] == stage_r[1] && stage_r[2] == stage_r[3] && stage_r[1] == stage_r[3];
  endproperty
  a_all_select: assert property (p_all_select)
    else $error("all-channel select missed a channel");

  property p_load_keeps_stage;
    fr_ok && f_cmd == 3'h1 |=> $stable(stage_r);
  endproperty
  a_load_keeps_stage: assert property (p_load_keeps_stage)
    else $error("load altered staging");

  property p_load_ignores_data;
    fr_ok && f_cmd == 3'h1 && chsel[2] |=> out_r == $past(stage_r);
  endproperty
  a_load_ignores_data: assert property (p_load_ignores_data)
    else $error("load data bits had effect");

  property p_mb_write;
    fr_ok && frame.multibyte && f_cmd == 3'h0 && chsel == 3'h1
      |=> stage_r[1] == $past(frame.sample_value);
  endproperty
  a_mb_write: assert property (p_mb_write)
    else $error("multibyte write not accepted");

  property p_mb_load;
    fr_ok && frame.multibyte && f_cmd == 3'h1 && sel[2]
      |=> out_r[2] == $past(stage_r[2]);
  endproperty
  a_mb_load: assert property (p_mb_load)
    else $error("multibyte load not accepted");

  property p_reserved_ignored;
    frame_valid && frame.reserved |=> $stable(stage_r) && $stable(out_r);
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored)
    else $error("frame with reserved bit acted");

  c_write:  cover property (fr_ok && f_cmd == 3'h0);
  c_load:   cover property (fr_ok && f_cmd == 3'h1 && chsel[2]);
  c_every:  cover property (fr_ok && f_cmd == 3'h2);
  c_chosen: cover property (fr_ok && frame.multibyte && f_cmd == 3'h3);
endmodule // dcld_decoder

/* dcld_frame_master.sv */
`timescale 1ns/10ps
module dcld_frame_master (
  input  wire logic                  aclk,
  output      logic                  frame_valid,
  output      dcld_pkg::dcld_frame_s frame
);
  import dcld_pkg::*;

  initial
  begin
    frame_valid = 1'b0;
    frame       = '0;
  end

  // One frame is one strobe; the lines show the inverse once released.
  task automatic send(input logic mb, input logic [2:0] cmd, input logic [2:0] sel,
                      input dcld_code_t code, input logic [3:0] pad);
    dcld_frame_s f;
    f = {1'b0, mb, cmd, sel, code, pad};
    send_raw(f);
  endtask

  // Sends a frame exactly as given, reserved bit included.
  task automatic send_raw(input dcld_frame_s f);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame       <= f;
    @(posedge aclk);
    frame_valid <= 1'b0;
    frame       <= ~f;
  endtask
endmodule // dcld_frame_master

/* testbench.sv */
`timescale 1ns/10ps
`include "dcld_defs.svh"
module testbench;
  import dcld_pkg::*;
  logic          aclk;
  logic          aresetn;
  logic          frame_valid;
  dcld_frame_s   frame;
  dcld_axi_req_s req;
  dcld_axi_rsp_s rsp;
  dcld_codes_t   dac_code;
  int            fails;
  int            n_tests;
  logic [11:0]   stage [4];
  logic [11:0]   outv [4];
  logic [3:0]    dirty;
  logic          transp;
  logic [31:0]   rd;
  logic [1:0]    resp;

  dcld_frame_master fm (.aclk(aclk), .frame_valid(frame_valid), .frame(frame));
  dcld_decoder DUT (.aclk(aclk), .aresetn(aresetn), .frame_valid(frame_valid),
                    .frame(frame), .axi_req(req), .axi_rsp(rsp), .dac_code(dac_code));

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF,
             bready: 1'b1, default: '0};
    do
    begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rd   = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Sends a frame, predicts staging and outputs, then compares all four outputs.
  task automatic frm(input logic mb, input logic [2:0] cmd, input logic [2:0] sel,
                     input logic [11:0] code, input logic [3:0] pad);
    logic [3:0] m;
    m = sel[2] ? 4'hF : 4'(1 << sel[1:0]);
    fm.send(mb, cmd, sel, code, pad);
    for (int i = 0; i < 4; i++)
      if (m[i] && cmd != `DCLD_CMD_LOAD)
      begin
        stage[i] = code;
        dirty[i] = 1'b1;
      end
    for (int i = 0; i < 4; i++)
      if ((cmd == `DCLD_CMD_LOAD && m[i]) || (cmd == `DCLD_CMD_WRITE_EVERY && dirty[i])
          || (cmd == `DCLD_CMD_WRITE_CHOSE && m[i] && dirty[i])
          || (transp && cmd == `DCLD_CMD_WRITE && m[i]))
      begin
        outv[i]  = stage[i];
        dirty[i] = 1'b0;
      end
    @(posedge aclk);
    #1;
    for (int i = 0; i < 4; i++)
      check(32'(dac_code[i]), 32'(outv[i]));
  endtask

  task automatic chk_stage;
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(8'({`DCLD_IDX_STAGE0 + 4'(i), 2'b00}));
      check(rd, 32'(stage[i]));
    end
  endtask

  task automatic chk_status(input logic [2:0] cmd, input logic mb);
    axi_rd(8'({`DCLD_IDX_STATUS, 2'b00}));
    check(rd, {24'h00_0000, dirty, cmd, mb});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_write;
    frm(1'b1, `DCLD_CMD_WRITE, 3'b001, 12'hA5C, 4'hF);
    chk_stage();
  endtask

  task automatic t_write_all;
    frm(1'b0, `DCLD_CMD_WRITE, 3'b110, 12'h3C1, 4'h0);
    frm(1'b0, `DCLD_CMD_WRITE, 3'b010, 12'h7E2, 4'h5);
    chk_stage();
  endtask

  task automatic t_load;
    frm(1'b0, `DCLD_CMD_LOAD, 3'b011, 12'h000, 4'h0);
    frm(1'b1, `DCLD_CMD_LOAD, 3'b101, 12'hFFF, 4'hF);
    chk_stage();
  endtask

  task automatic t_combined;
    frm(1'b0, `DCLD_CMD_WRITE, 3'b010, 12'h111, 4'h0);
    frm(1'b1, `DCLD_CMD_WRITE_EVERY, 3'b000, 12'h222, 4'h3);
    frm(1'b0, `DCLD_CMD_WRITE, 3'b011, 12'h444, 4'h0);
    frm(1'b0, `DCLD_CMD_WRITE_CHOSE, 3'b001, 12'h333, 4'h0);
    chk_status(`DCLD_CMD_WRITE_CHOSE, 1'b0);
  endtask

  // Frames with the reserved bit set change nothing; a command above 3 changes only the last command and multibyte status bits.
  task automatic t_ignored;
    fm.send_raw({1'b1, 1'b0, `DCLD_CMD_WRITE, 3'b100, 12'hBAD, 4'h0});
    fm.send(1'b0, 3'h4, 3'b100, 12'h5A5, 4'h0);
    @(posedge aclk);
    #1;
    for (int i = 0; i < 4; i++)
      check(32'(dac_code[i]), 32'(outv[i]));
    chk_stage();
  endtask

  // A reset in mid-run clears staging, outputs, dirty marks and the latch mode.
  task automatic t_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    transp = 1'b0;
    dirty  = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      stage[i] = 12'h000;
      outv[i]  = 12'h000;
    end
    @(posedge aclk);
    #1;
    for (int i = 0; i < 4; i++)
      check(32'(dac_code[i]), 32'(outv[i]));
    chk_stage();
    axi_rd(8'({`DCLD_IDX_CTRL, 2'b00}));
    check(rd, 32'h0);
    chk_status(3'h0, 1'b0);
  endtask

  task automatic t_regs;
    axi_wr(8'h08, 32'h1);
    check(32'(resp), 32'(`DCLD_RESP_SLVERR));
    axi_rd(8'h30);
    check({rd[31:2], resp}, 32'(`DCLD_RESP_SLVERR));
    axi_wr(8'({`DCLD_IDX_STAGE0, 2'b00}), 32'hFFF);
    check(32'(resp), 32'(`DCLD_RESP_OKAY));
    chk_stage();
    axi_wr(8'({`DCLD_IDX_CTRL, 2'b00}), 32'h1);
    axi_rd(8'({`DCLD_IDX_CTRL, 2'b00}));
    check(rd, 32'h1);
    transp = 1'b1;
    frm(1'b0, `DCLD_CMD_WRITE, 3'b000, 12'h9AB, 4'h0);
  endtask

  initial
  begin
    fails   = 0;
    n_tests = 0;
    dirty   = 4'h0;
    transp  = 1'b0;
    req     = '0;
    aresetn = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      stage[i] = 12'h000;
      outv[i]  = 12'h000;
    end
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_write();
    t_write_all();
    t_load();
    t_combined();
    t_ignored();
    t_regs();
    t_reset();
    final_report();
  end

  initial
  begin
    #40000;
    fails++;
    final_report();
  end
endmodule // testbench
